// file: pcat_support_pkg.sv
// constants, field layouts and encodings for the pc/at system support block
// assumes an 8-bit i/o port space decoded on a 16-bit address
package pcat_support_pkg;

  // ----------------------------------------------------------------
  // i/o port addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] PORT_MISC_ADDR = 16'h0061;
  localparam logic [15:0] PORT_NMI_ADDR = 16'h0070;
  localparam logic [15:0] PORT_FAST_ADDR = 16'h0092;
  localparam logic [15:0] PORT_CFG_INDEX_ADDR = 16'h03d4;
  localparam logic [15:0] PORT_CFG_DATA_ADDR = 16'h03d5;
  localparam logic [15:0] PORT_KBC_DATA_ADDR = 16'h0060;
  localparam logic [15:0] PORT_KBC_CMD_ADDR = 16'h0064;

  // ----------------------------------------------------------------
  // indexed configuration registers
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_BUS_MODE_INIT = 8'h19;
  localparam logic [7:0] IDX_PRINTER_SELECT = 8'h20;
  localparam logic [7:0] IDX_MISC1 = 8'h6f;
  localparam logic [7:0] BUS_MODE_LOCK_MASK = 8'h80;
  localparam logic [7:0] BUS_MODE_RESET = 8'h00;

  // printer port placement, address bits 15:4 of each window
  typedef enum logic [1:0] {
    PRN_OFF = 2'h0,
    PRN_AT_3B = 2'h1,
    PRN_AT_37 = 2'h2,
    PRN_AT_27 = 2'h3
  } printer_sel_t;
  localparam logic [11:0] PRN_BASE_3B = 12'h03b;
  localparam logic [11:0] PRN_BASE_37 = 12'h037;
  localparam logic [11:0] PRN_BASE_27 = 12'h027;
  localparam int PRN_SEL_LSB = 0;

  // ----------------------------------------------------------------
  // miscellaneous control port fields
  // ----------------------------------------------------------------
  localparam int MF_TIMER_GATE = 0;
  localparam int MF_SPEAKER = 1;
  localparam int MF_PARITY_EN_N = 2;
  localparam int MF_IOCHK_EN_N = 3;
  localparam int MF_REFRESH = 4;
  localparam int MF_TIMER_OUT = 5;
  localparam int MF_IOCHK = 6;
  localparam int MF_PARITY = 7;
  localparam logic [3:0] MF_CTRL_RESET = 4'hc;
  localparam logic [3:0] MF_KBD_RESET = 4'h0;

  // nmi mask and clock-calendar index
  localparam int NMI_MASK_BIT = 7;
  localparam logic NMI_MASK_RESET = 1'b1;
  localparam logic [6:0] RTC_INDEX_RESET = 7'h00;

  // fast control fields, shared by port 92h and misc1
  localparam int FC_FAST_RESET = 0;
  localparam int FC_ADDR20 = 1;
  localparam int FC_XT_KBD = 2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int REFRESH_PERIOD_NS = 15000;
  localparam int REFRESH_CYCLES = (REFRESH_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SHUTDOWN_RESET_CYCLES = 16;
  localparam int KBC_CLK_HALF_CYCLES = 14;

endpackage : pcat_support_pkg

// file: cpu_reset_if.sv
// request and answer wires between the support logic and the cpu reset generator
// assumes both ends run on core_clk
`timescale 1ns/1ps
interface cpu_reset_if;
  logic hwReset;
  logic pinResetReq;
  logic fastResetReq;
  logic shutdownStatus;
  logic cpuReset;

  modport gen (
    input hwReset,
    input pinResetReq,
    input fastResetReq,
    input shutdownStatus,
    output cpuReset
  );
  modport ctl (
    output hwReset,
    output pinResetReq,
    output fastResetReq,
    output shutdownStatus,
    input cpuReset
  );
endinterface : cpu_reset_if

// file: cpu_reset_gen.sv
// cpu-only reset generator: hardware, pin, fast and shutdown reset sources
// assumes all requests are already in the core_clk domain
`timescale 1ns/1ps
module cpu_reset_gen #(
  parameter int HOLD_CYCLES = pcat_support_pkg::SHUTDOWN_RESET_CYCLES
) (
  input wire logic core_clk,
  cpu_reset_if.gen rq
);
  localparam int CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] HOLD_LOAD = CW'(HOLD_CYCLES);

  // ----------------------------------------------------------------
  // stretch counter
  // ----------------------------------------------------------------
  logic [CW-1:0] holdCount_ff, nxt_holdCount;
  logic shutdownSeen_ff, nxt_shutdownSeen;
  logic shutdownEdge;

  assign shutdownEdge = rq.shutdownStatus & ~shutdownSeen_ff;

  always_comb begin
    nxt_shutdownSeen = rq.shutdownStatus;
    nxt_holdCount = holdCount_ff;
    if (rq.hwReset || rq.pinResetReq || rq.fastResetReq || shutdownEdge) begin
      nxt_holdCount = HOLD_LOAD;
    end else if (holdCount_ff != '0) begin
      nxt_holdCount = holdCount_ff - CW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rq.hwReset) begin
      holdCount_ff <= HOLD_LOAD;
      shutdownSeen_ff <= 1'b0;
    end else begin
      holdCount_ff <= nxt_holdCount;
      shutdownSeen_ff <= nxt_shutdownSeen;
    end
  end

  assign rq.cpuReset = (holdCount_ff != '0) | rq.pinResetReq;

  // ----------------------------------------------------------------
  // shutdown hold check: age of the last shutdown edge, in cycles
  // ----------------------------------------------------------------
  logic [CW-1:0] sdAge_ff, nxt_sdAge;

  always_comb begin
    nxt_sdAge = '0;
    if (shutdownEdge) begin
      nxt_sdAge = CW'(1);
    end else if (sdAge_ff != '0 && sdAge_ff != HOLD_LOAD) begin
      nxt_sdAge = sdAge_ff + CW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rq.hwReset) begin
      sdAge_ff <= '0;
    end else begin
      sdAge_ff <= nxt_sdAge;
    end
  end

  chk_shutdown_hold: assert property (@(posedge core_clk) disable iff (rq.hwReset)
    (sdAge_ff != '0) |-> rq.cpuReset)
    else $error("shutdown reset shorter than sixteen cycles");

endmodule : cpu_reset_gen

// file: pcat_system_support.sv
// pc/at system support: printer port mapping, misc control port, nmi mask,
// speaker paths, addr20 gating, hardware and cpu reset control
// assumes the cpu core drives i/o strobes for one core_clk cycle each
//
// Behaviour
// - printer port placed at 3Bxh, 37xh, 27xh or switched off by software
// - printer interrupt always goes to line 7, whatever the placement
// - placement set at index 20h; ignored once index 19h holds its mandatory bits
// - port 61h is 8 bits; low nibble read/write nmi source and sound enables
// - port 61h upper nibble reads status, written value steers legacy keyboard
// - bit 7 of port 70h, active low, blocks every nmi when set
// - nmi mask bit set to 1 by reset; port 70h has no read path
// - low seven bits of port 70h are write-only clock-calendar index bits
// - speaker driven from timer channel 2 output
// - timer channel 2 gate driven by the timer-gate bit of port 61h
// - speaker also driven directly by the speaker-data bit of port 61h
// - external addr20 gate high passes cpu address bit 20 through
// - gate low with internal gating unused forces system address bit 20 low
// - internal addr20 and fast reset controlled from index 6Fh and port 92h
// - power-good reset clears everything except retained configuration bits
// - battery-disconnect reset clears all internal logic
// - both hardware reset pins synchronised to core_clk first
// - pin and fast resets reset only the cpu
// - cpu shutdown status gives a cpu reset of at least sixteen cycles
// - chip select and clock generated for external keyboard controller, or legacy mode
`timescale 1ns/1ps
module pcat_system_support #(
  parameter int REFRESH_CYCLES = pcat_support_pkg::REFRESH_CYCLES,
  parameter int KBC_HALF = pcat_support_pkg::KBC_CLK_HALF_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic power_good_reset_n,
  input wire logic battery_disconnect_reset_n,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWrData,
  input wire logic ioWrStb,
  input wire logic ioRdStb,
  output logic [7:0] ioRdData,
  output logic ioRdValid,
  input wire logic cpuAddr20,
  output logic sysAddr20,
  input wire logic external_addr20_gate,
  input wire logic timer_ch2_output,
  output logic timerCh2Gate,
  output logic speakerOut,
  input wire logic parityErrorPin,
  input wire logic ioCheckPin,
  output logic nmiOut,
  output logic [6:0] rtcIndex,
  output logic rtcIndexWrite,
  output logic [3:0] legacyKbdCtl,
  output logic firstPrinterPortSel,
  input wire logic printerIrqReq,
  output logic irq7Out,
  output logic kbcCs_n,
  output logic kbcClk,
  input wire logic cpu_reset_request_pin,
  input wire logic cpuShutdownStatus,
  output logic cpuReset
);
  localparam int RCW = $clog2(REFRESH_CYCLES + 1);
  localparam int KCW = $clog2(KBC_HALF + 1);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pinMeta_ff, pinSync_ff;
  logic pgResetSync, bdResetSync, gateSync, parSync, chkSync, rcSync;

  always_ff @(posedge core_clk) begin
    pinMeta_ff <= {power_good_reset_n, battery_disconnect_reset_n, external_addr20_gate,
                   parityErrorPin, ioCheckPin, cpu_reset_request_pin};
    pinSync_ff <= pinMeta_ff;
  end

  assign pgResetSync = ~pinSync_ff[5];
  assign bdResetSync = ~pinSync_ff[4];
  assign gateSync = pinSync_ff[3];
  assign parSync = pinSync_ff[2];
  assign chkSync = pinSync_ff[1];
  assign rcSync = pinSync_ff[0];

  // full reset clears retained configuration too; power-good reset spares it
  logic fullReset, hwReset;
  assign fullReset = rst | bdResetSync;
  assign hwReset = fullReset | pgResetSync;

  // ----------------------------------------------------------------
  // port decode
  // ----------------------------------------------------------------
  logic wrMisc, wrNmi, wrFast, wrIndex, wrData, rdMisc, rdFast, rdIndex, rdData;
  assign wrMisc = ioWrStb & (ioAddr == pcat_support_pkg::PORT_MISC_ADDR);
  assign wrNmi = ioWrStb & (ioAddr == pcat_support_pkg::PORT_NMI_ADDR);
  assign wrFast = ioWrStb & (ioAddr == pcat_support_pkg::PORT_FAST_ADDR);
  assign wrIndex = ioWrStb & (ioAddr == pcat_support_pkg::PORT_CFG_INDEX_ADDR);
  assign wrData = ioWrStb & (ioAddr == pcat_support_pkg::PORT_CFG_DATA_ADDR);
  assign rdMisc = ioRdStb & (ioAddr == pcat_support_pkg::PORT_MISC_ADDR);
  assign rdFast = ioRdStb & (ioAddr == pcat_support_pkg::PORT_FAST_ADDR);
  assign rdIndex = ioRdStb & (ioAddr == pcat_support_pkg::PORT_CFG_INDEX_ADDR);
  assign rdData = ioRdStb & (ioAddr == pcat_support_pkg::PORT_CFG_DATA_ADDR);

  // ----------------------------------------------------------------
  // retained configuration: printer placement and bus-mode init
  // ----------------------------------------------------------------
  pcat_support_pkg::printer_sel_t prnSel_ff, nxt_prnSel;
  logic [7:0] busMode_ff, nxt_busMode;
  logic [7:0] cfgIndex_ff, nxt_cfgIndex;
  logic busLocked;

  assign busLocked = (busMode_ff & pcat_support_pkg::BUS_MODE_LOCK_MASK) == pcat_support_pkg::BUS_MODE_LOCK_MASK;

  always_comb begin
    nxt_prnSel = prnSel_ff;
    nxt_busMode = busMode_ff;
    nxt_cfgIndex = cfgIndex_ff;
    if (wrIndex) begin
      nxt_cfgIndex = ioWrData;
    end
    if (wrData && cfgIndex_ff == pcat_support_pkg::IDX_BUS_MODE_INIT) begin
      nxt_busMode = ioWrData;
    end
    if (wrData && cfgIndex_ff == pcat_support_pkg::IDX_PRINTER_SELECT && !busLocked) begin
      nxt_prnSel = pcat_support_pkg::printer_sel_t'(ioWrData[pcat_support_pkg::PRN_SEL_LSB +: 2]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (fullReset) begin
      prnSel_ff <= pcat_support_pkg::PRN_OFF;
      busMode_ff <= pcat_support_pkg::BUS_MODE_RESET;
    end else begin
      prnSel_ff <= nxt_prnSel;
      busMode_ff <= nxt_busMode;
    end
    if (hwReset) begin
      cfgIndex_ff <= '0;
    end else begin
      cfgIndex_ff <= nxt_cfgIndex;
    end
  end

  // ----------------------------------------------------------------
  // printer port decode and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    unique case (prnSel_ff)
      pcat_support_pkg::PRN_AT_3B: firstPrinterPortSel = ioAddr[15:4] == pcat_support_pkg::PRN_BASE_3B;
      pcat_support_pkg::PRN_AT_37: firstPrinterPortSel = ioAddr[15:4] == pcat_support_pkg::PRN_BASE_37;
      pcat_support_pkg::PRN_AT_27: firstPrinterPortSel = ioAddr[15:4] == pcat_support_pkg::PRN_BASE_27;
      pcat_support_pkg::PRN_OFF: firstPrinterPortSel = 1'b0;
    endcase
  end

  assign irq7Out = printerIrqReq;

  // ----------------------------------------------------------------
  // misc control port, nmi mask, fast controls
  // ----------------------------------------------------------------
  logic [3:0] mfCtrl_ff, nxt_mfCtrl;
  logic [3:0] mfKbd_ff, nxt_mfKbd;
  logic nmiMask_ff, nxt_nmiMask;
  logic [6:0] rtcIdx_ff, nxt_rtcIdx;
  logic rtcWr_ff, nxt_rtcWr;
  logic a20Int_ff, nxt_a20Int;
  logic xtKbd_ff, nxt_xtKbd;
  logic fastReq_ff, nxt_fastReq;
  logic wrMisc1;

  assign wrMisc1 = wrData & (cfgIndex_ff == pcat_support_pkg::IDX_MISC1);

  always_comb begin
    nxt_mfCtrl = mfCtrl_ff;
    nxt_mfKbd = mfKbd_ff;
    nxt_nmiMask = nmiMask_ff;
    nxt_rtcIdx = rtcIdx_ff;
    nxt_rtcWr = wrNmi;
    nxt_a20Int = a20Int_ff;
    nxt_xtKbd = xtKbd_ff;
    nxt_fastReq = 1'b0;
    if (wrMisc) begin
      nxt_mfCtrl = ioWrData[3:0];
      nxt_mfKbd = ioWrData[7:4];
    end
    if (wrNmi) begin
      nxt_nmiMask = ioWrData[pcat_support_pkg::NMI_MASK_BIT];
      nxt_rtcIdx = ioWrData[6:0];
    end
    if (wrFast || wrMisc1) begin
      nxt_a20Int = ioWrData[pcat_support_pkg::FC_ADDR20];
      nxt_fastReq = ioWrData[pcat_support_pkg::FC_FAST_RESET];
    end
    if (wrMisc1) begin
      nxt_xtKbd = ioWrData[pcat_support_pkg::FC_XT_KBD];
    end
  end

  always_ff @(posedge core_clk) begin
    if (hwReset) begin
      mfCtrl_ff <= pcat_support_pkg::MF_CTRL_RESET;
      mfKbd_ff <= pcat_support_pkg::MF_KBD_RESET;
      nmiMask_ff <= pcat_support_pkg::NMI_MASK_RESET;
      rtcIdx_ff <= pcat_support_pkg::RTC_INDEX_RESET;
      rtcWr_ff <= 1'b0;
      a20Int_ff <= 1'b0;
      xtKbd_ff <= 1'b0;
      fastReq_ff <= 1'b0;
    end else begin
      mfCtrl_ff <= nxt_mfCtrl;
      mfKbd_ff <= nxt_mfKbd;
      nmiMask_ff <= nxt_nmiMask;
      rtcIdx_ff <= nxt_rtcIdx;
      rtcWr_ff <= nxt_rtcWr;
      a20Int_ff <= nxt_a20Int;
      xtKbd_ff <= nxt_xtKbd;
      fastReq_ff <= nxt_fastReq;
    end
  end

  assign rtcIndex = rtcIdx_ff;
  assign rtcIndexWrite = rtcWr_ff;
  assign legacyKbdCtl = mfKbd_ff;

  // nmi sources: enables are active low, master mask blocks all
  assign nmiOut = ~nmiMask_ff & ((parSync & ~mfCtrl_ff[pcat_support_pkg::MF_PARITY_EN_N])
                               | (chkSync & ~mfCtrl_ff[pcat_support_pkg::MF_IOCHK_EN_N]));

  // ----------------------------------------------------------------
  // speaker and addr20
  // ----------------------------------------------------------------
  assign timerCh2Gate = mfCtrl_ff[pcat_support_pkg::MF_TIMER_GATE];
  assign speakerOut = timer_ch2_output | mfCtrl_ff[pcat_support_pkg::MF_SPEAKER];
  // address path is combinational so bit 20 keeps cpu timing
  assign sysAddr20 = cpuAddr20 & (gateSync | a20Int_ff);

  // ----------------------------------------------------------------
  // refresh toggle and keyboard controller clock
  // ----------------------------------------------------------------
  logic [RCW-1:0] refCount_ff, nxt_refCount;
  logic refToggle_ff, nxt_refToggle;
  logic [KCW-1:0] kbcCount_ff, nxt_kbcCount;
  logic kbcClk_ff, nxt_kbcClk;

  always_comb begin
    nxt_refCount = refCount_ff - RCW'(1);
    nxt_refToggle = refToggle_ff;
    nxt_kbcCount = kbcCount_ff - KCW'(1);
    nxt_kbcClk = kbcClk_ff;
    if (refCount_ff == '0) begin
      nxt_refCount = RCW'(REFRESH_CYCLES - 1);
      nxt_refToggle = ~refToggle_ff;
    end
    if (kbcCount_ff == '0) begin
      nxt_kbcCount = KCW'(KBC_HALF - 1);
      nxt_kbcClk = ~kbcClk_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (hwReset) begin
      refCount_ff <= RCW'(REFRESH_CYCLES - 1);
      refToggle_ff <= 1'b0;
      kbcCount_ff <= KCW'(KBC_HALF - 1);
      kbcClk_ff <= 1'b0;
    end else begin
      refCount_ff <= nxt_refCount;
      refToggle_ff <= nxt_refToggle;
      kbcCount_ff <= nxt_kbcCount;
      kbcClk_ff <= nxt_kbcClk;
    end
  end

  assign kbcClk = kbcClk_ff;
  assign kbcCs_n = ~(~xtKbd_ff & (ioWrStb | ioRdStb)
                   & (ioAddr == pcat_support_pkg::PORT_KBC_DATA_ADDR
                      || ioAddr == pcat_support_pkg::PORT_KBC_CMD_ADDR));

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] rdData_ff, nxt_rdData;
  logic rdValid_ff, nxt_rdValid;
  logic [7:0] fastView;

  assign fastView = {5'h00, xtKbd_ff, a20Int_ff, 1'b0};

  always_comb begin
    nxt_rdValid = rdMisc | rdFast | rdIndex | rdData;
    nxt_rdData = 8'h00;
    if (rdMisc) begin
      nxt_rdData = {parSync, chkSync, timer_ch2_output, refToggle_ff, mfCtrl_ff};
    end else if (rdFast) begin
      nxt_rdData = fastView;
    end else if (rdIndex) begin
      nxt_rdData = cfgIndex_ff;
    end else if (rdData) begin
      unique case (cfgIndex_ff)
        pcat_support_pkg::IDX_BUS_MODE_INIT: nxt_rdData = busMode_ff;
        pcat_support_pkg::IDX_PRINTER_SELECT: nxt_rdData = {6'h00, prnSel_ff};
        pcat_support_pkg::IDX_MISC1: nxt_rdData = fastView;
        default: nxt_rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (hwReset) begin
      rdData_ff <= 8'h00;
      rdValid_ff <= 1'b0;
    end else begin
      rdData_ff <= nxt_rdData;
      rdValid_ff <= nxt_rdValid;
    end
  end

  assign ioRdData = rdData_ff;
  assign ioRdValid = rdValid_ff;

  // ----------------------------------------------------------------
  // cpu reset generator
  // ----------------------------------------------------------------
  cpu_reset_if rstIf ();
  assign rstIf.hwReset = hwReset;
  assign rstIf.pinResetReq = rcSync;
  assign rstIf.fastResetReq = fastReq_ff;
  assign rstIf.shutdownStatus = cpuShutdownStatus;
  assign cpuReset = rstIf.cpuReset;

  cpu_reset_gen #(
    .HOLD_CYCLES(pcat_support_pkg::SHUTDOWN_RESET_CYCLES)
  ) u_cpu_reset_gen (
    .core_clk(core_clk),
    .rq(rstIf.gen)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_nmi_mask_block: assert property (@(posedge core_clk) disable iff (hwReset)
    nmiMask_ff |-> !nmiOut)
    else $error("nmi passed while masked");

  chk_nmi_reset_value: assert property (@(posedge core_clk) disable iff (rst)
    $past(hwReset) |-> nmiMask_ff)
    else $error("nmi mask not set after reset");

  chk_printer_lock: assert property (@(posedge core_clk) disable iff (fullReset)
    (wrData && busLocked && cfgIndex_ff == pcat_support_pkg::IDX_PRINTER_SELECT) |=> $stable(prnSel_ff))
    else $error("printer remapped while bus mode locked");

  chk_printer_off: assert property (@(posedge core_clk) disable iff (hwReset)
    (prnSel_ff == pcat_support_pkg::PRN_OFF) |-> !firstPrinterPortSel)
    else $error("printer select while disabled");

  chk_irq7_route: assert property (@(posedge core_clk) disable iff (hwReset)
    $rose(printerIrqReq) |-> irq7Out)
    else $error("printer interrupt not on line 7");

  chk_addr20_low: assert property (@(posedge core_clk) disable iff (hwReset)
    (!gateSync && !a20Int_ff) |-> !sysAddr20)
    else $error("addr20 not forced low");

  chk_addr20_pass: assert property (@(posedge core_clk) disable iff (hwReset)
    gateSync |-> (sysAddr20 == cpuAddr20))
    else $error("addr20 not passed with gate high");

  chk_fast_reset: assert property (@(posedge core_clk) disable iff (hwReset)
    (wrFast && ioWrData[pcat_support_pkg::FC_FAST_RESET]) |=> ##1 cpuReset [*8])
    else $error("fast reset did not reach the cpu");

  chk_pg_sync: assert property (@(posedge core_clk) disable iff (rst)
    $fell(power_good_reset_n) |-> ##2 hwReset)
    else $error("power-good reset not synchronised in two cycles");

  chk_kbc_select: assert property (@(posedge core_clk) disable iff (hwReset)
    (xtKbd_ff && ioRdStb && ioAddr == pcat_support_pkg::PORT_KBC_DATA_ADDR) |-> kbcCs_n)
    else $error("keyboard controller selected in legacy mode");

endmodule : pcat_system_support

// file: pcat_timer_model.sv
// timer channel 2 model standing on the far side of the speaker path
// assumes one core_clk domain and a synchronous active-high rst
`timescale 1ns/1ps
module pcat_timer_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic timerCh2Gate,
  output logic timer_ch2_output
);
  // ----------------------------------------
  // square wave, held low while the gate is low
  // ----------------------------------------
  logic wave_ff;
  logic nxt_wave;
  always_comb begin
    nxt_wave = wave_ff;
    if (timerCh2Gate) begin
      nxt_wave = ~wave_ff;
    end
  end
  always_ff @(posedge core_clk) begin
    wave_ff <= rst ? 1'b0 : nxt_wave;
  end
  assign timer_ch2_output = wave_ff & timerCh2Gate;
endmodule : pcat_timer_model

// file: pcat_system_support_tb_top.sv
// self-checking bench for the pc/at system support block
// assumes the design package and cpu reset interface are compiled first
`timescale 1ns/1ps
module pcat_system_support_tb_top;
  // ----------------------------------------
  // clock, stimulus and design
  // ----------------------------------------
  logic core_clk = 0, rst = 1, pg_n = 1, bd_n = 1, wr = 0, rd = 0;
  logic [15:0] ioAddr = 16'h0000;
  logic [7:0] ioWrData = 8'h00, ioRdData, d, w;
  logic ioRdValid, cpuAddr20 = 0, sysAddr20, gate = 0, t2, timerCh2Gate, speakerOut;
  logic par = 0, chk = 0, nmiOut, rtcIndexWrite, firstPrinterPortSel, irqReq = 0, irq7Out;
  logic kbcCs_n, kbcClk, pinReq = 0, shut = 0, cpuReset, v, k;
  logic [6:0] rtcIndex;
  logic [3:0] legacyKbdCtl;
  int err_total = 0, n_compared = 0, n;
  `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
    $display("wrong value at %0t: %h not %h", $time, (a), (b)); end end
  initial forever #2 core_clk = ~core_clk;
  pcat_system_support #(.REFRESH_CYCLES(8), .KBC_HALF(2)) i_dut (.core_clk(core_clk), .rst(rst),
    .power_good_reset_n(pg_n), .battery_disconnect_reset_n(bd_n), .ioAddr(ioAddr),
    .ioWrData(ioWrData), .ioWrStb(wr), .ioRdStb(rd), .ioRdData(ioRdData), .ioRdValid(ioRdValid),
    .cpuAddr20(cpuAddr20), .sysAddr20(sysAddr20), .external_addr20_gate(gate),
    .timer_ch2_output(t2), .timerCh2Gate(timerCh2Gate), .speakerOut(speakerOut),
    .parityErrorPin(par), .ioCheckPin(chk), .nmiOut(nmiOut), .rtcIndex(rtcIndex),
    .rtcIndexWrite(rtcIndexWrite), .legacyKbdCtl(legacyKbdCtl),
    .firstPrinterPortSel(firstPrinterPortSel), .printerIrqReq(irqReq), .irq7Out(irq7Out),
    .kbcCs_n(kbcCs_n), .kbcClk(kbcClk), .cpu_reset_request_pin(pinReq),
    .cpuShutdownStatus(shut), .cpuReset(cpuReset));
  pcat_timer_model i_timer (.core_clk(core_clk), .rst(rst), .timerCh2Gate(timerCh2Gate),
    .timer_ch2_output(t2));
  // ----------------------------------------
  // bus cycles and helpers
  // ----------------------------------------
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic wio(input logic [15:0] a, input logic [7:0] x);
    cyc(1);
    ioAddr = a;
    ioWrData = x;
    wr = 1;
    cyc(1);
    wr = 0;
  endtask : wio
  task automatic rio(input logic [15:0] a);
    cyc(1);
    ioAddr = a;
    rd = 1;
    cyc(1);
    rd = 0;
    v = ioRdValid;
    d = ioRdData;
  endtask : rio
  task automatic cfg(input logic [7:0] i, input logic [7:0] x);
    wio(16'h03d4, i);
    wio(16'h03d5, x);
  endtask : cfg
  task automatic held;
    n = 0;
    repeat (40) begin
      n += int'(cpuReset === 1'b1);
      cyc(1);
    end
  endtask : held
  function automatic logic [11:0] base(input int s);
    return s == 1 ? 12'h03b : s == 2 ? 12'h037 : 12'h027;
  endfunction : base
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    #40000;
    err_total++;
    end_of_test();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'hf1eae816));
    par = 1;
    cyc(4);
    rst = 0;
    held();
    `CHK(n, 16)
    `CHK(nmiOut, 1'b0)
    rio(16'h0061);
    `CHK({v, d[3:0]}, 5'h1c)
    rio(16'h0071);
    `CHK(v, 1'b0)
    $display("test reset done");
    repeat (6) begin
      w = 8'($urandom());
      wio(16'h0061, w);
      `CHK({timerCh2Gate, legacyKbdCtl}, {w[0], w[7:4]})
      `CHK(legacyKbdCtl, w[7:4])
      `CHK(speakerOut, w[1] | t2)
      if (!w[0]) `CHK(speakerOut, w[1])
      k = w[2];
      rio(16'h0061);
      `CHK(d[3:0], w[3:0])
      `CHK({v, d[7:6]}, {1'b1, par, chk})
      d = {1'b0, 7'($urandom())};
      wio(16'h0070, d);
      `CHK(rtcIndex, d[6:0])
      `CHK(rtcIndexWrite, 1'b1)
      cyc(3);
      `CHK(nmiOut, ~k)
      wio(16'h0070, d | 8'h80);
      `CHK(nmiOut, 1'b0)
    end
    $display("test misc and nmi done");
    for (int i = 0; i < 8; i++) begin
      wio(16'h0092, {6'h00, i[1], 1'b0});
      gate = i[0];
      cpuAddr20 = i[2];
      cyc(3);
      `CHK(sysAddr20, i[2] & (i[0] | i[1]))
      `CHK(gate | i[1] ? sysAddr20 : ~sysAddr20, cpuAddr20 | ~(gate | i[1]))
    end
    cfg(8'h6f, 8'h02);
    gate = 0;
    cpuAddr20 = 1;
    cyc(3);
    `CHK(sysAddr20, 1'b1)
    cfg(8'h6f, 8'h00);
    `CHK(sysAddr20, 1'b0)
    $display("test addr20 done");
    for (int s = 0; s < 4; s++) begin
      cfg(8'h20, 8'(s));
      irqReq = 1'($urandom());
      ioAddr = {(s == 0 ? 12'h03b : base(s)), 4'($urandom())};
      cyc(1);
      `CHK(firstPrinterPortSel, s != 0)
      `CHK(irq7Out, irqReq)
    end
    cfg(8'h19, 8'h80);
    cfg(8'h20, 8'h01);
    rio(16'h03d5);
    `CHK(d, 8'h03)
    $display("test printer done");
    wio(16'h0092, 8'h01);
    held();
    `CHK(n >= 16 && n < 20, 1'b1)
    rio(16'h03d5);
    `CHK(d, 8'h03)
    cyc(1);
    shut = 1;
    held();
    shut = 0;
    `CHK(n >= 16, 1'b1)
    pinReq = 1;
    cyc(4);
    `CHK(cpuReset, 1'b1)
    pinReq = 0;
    k = kbcClk;
    cyc(2);
    `CHK(kbcClk, ~k)
    for (int i = 1; i >= 0; i--) begin
      cfg(8'h6f, {5'h00, i[0], 2'h0});
      ioAddr = 16'h0060;
      rd = 1;
      #1;
      `CHK(kbcCs_n, i[0])
      cyc(1);
      rd = 0;
    end
    $display("test cpu reset done");
    pg_n = 0;
    cyc(4);
    pg_n = 1;
    held();
    wio(16'h03d4, 8'h20);
    rio(16'h03d5);
    `CHK(d, 8'h03)
    `CHK(nmiOut, 1'b0)
    bd_n = 0;
    cyc(4);
    bd_n = 1;
    held();
    wio(16'h03d4, 8'h20);
    rio(16'h03d5);
    `CHK(d, 8'h00)
    $display("test hardware reset done");
    end_of_test();
  end
endmodule : pcat_system_support_tb_top
